// ===== atasec_map.svh
`ifndef ATASEC_MAP_SVH
`define ATASEC_MAP_SVH
// Task-file offsets on the register port
`define ATASEC_OFF_DATA 3'h0
`define ATASEC_OFF_ERRFEAT 3'h1
`define ATASEC_OFF_SCNT 3'h2
`define ATASEC_OFF_SNUM 3'h3
`define ATASEC_OFF_CYLLO 3'h4
`define ATASEC_OFF_CYLHI 3'h5
`define ATASEC_OFF_DRVHD 3'h6
`define ATASEC_OFF_STATCMD 3'h7
// Opcodes
`define ATASEC_OP_SENSE 8'h03
`define ATASEC_OP_SETPW 8'hf1
`define ATASEC_OP_UNLOCK 8'hf2
`define ATASEC_OP_PREP 8'hf3
`define ATASEC_OP_ERASE 8'hf4
`define ATASEC_OP_FREEZE 8'hf5
`define ATASEC_OP_DISPW 8'hf6
`define ATASEC_GRP_RECAL 4'h1
`define ATASEC_GRP_SEEK 4'h7
// Extended error codes
`define ATASEC_EXT_NONE 8'h00
`define ATASEC_EXT_SELFOK 8'h01
`define ATASEC_EXT_MISC 8'h09
`define ATASEC_EXT_BADADDR 8'h21
`define ATASEC_EXT_OVFL 8'h2f
`define ATASEC_EXT_VOLT_A 8'h35
`define ATASEC_EXT_VOLT_B 8'h36
`define ATASEC_EXT_UNCORR 8'h11
`define ATASEC_EXT_CORR 8'h18
`define ATASEC_EXT_ABORT 8'h1f
`define ATASEC_EXT_DIAG_A 8'h05
`define ATASEC_EXT_DIAG_B 8'h37
`define ATASEC_EXT_DIAG_C 8'h3e
`define ATASEC_EXT_SPARES 8'h3a
`define ATASEC_EXT_FORMAT 8'h0c
`define ATASEC_EXT_WRFAIL 8'h03
// Status and error bit positions
`define ATASEC_ST_BSY 7
`define ATASEC_ST_RDY 6
`define ATASEC_ST_DRQ 3
`define ATASEC_ST_ERR 0
`define ATASEC_ER_IDNF 4
`define ATASEC_ER_ABRT 2
// Error register values
`define ATASEC_ERRV_IDNF 8'h10
`define ATASEC_ERRV_ABRT 8'h04
// Password sector layout and drive/head LBA bit
`define ATASEC_CTL_ID 0
`define ATASEC_CTL_LVL 8
`define ATASEC_LBA_BIT 6
`define ATASEC_LAST_WORD 9'h0ff
`define ATASEC_PW_FIRST 9'h001
`define ATASEC_PW_LAST 9'h010
`endif

// ===== atasec_pkg.sv
package atasec_pkg;
    typedef enum logic [2:0] {
        ATASEC_IDLE = 3'b000,
        ATASEC_DECODE = 3'b001,
        ATASEC_XFER = 3'b010,
        ATASEC_EXEC = 3'b011
    } atasec_st_t;

    typedef struct packed {
        atasec_st_t st;
        logic [7:0] cmd;
        logic [7:0] feat;
        logic [7:0] scnt;
        logic [7:0] snum;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] drv_hd;
        logic [7:0] err;
        logic err_flag;
        logic [7:0] ext;
        logic [8:0] wcnt;
        logic [15:0] ctl;
        logic [255:0] pw;
        logic [255:0] user_pw;
        logic [255:0] master_pw;
        logic user_set;
        logic locked;
        logic level_max;
        logic frozen;
        logic erase_armed;
        logic [15:0] rdata;
        logic done;
        logic erase_go;
        logic wear_go;
        logic hw_s1;
        logic hw_s2;
    } atasec_state_t;
endpackage

// ===== atasec_cmd.sv
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "atasec_map.svh"
// Contract
// - Recalibrate opcodes complete at once with no media action.
// - Request sense places the previous extended error code in the error register.
// - Extended code is zero for no error, own code for self test OK.
// - Invalid head or sector and address overflow report separate codes.
// - Voltage faults use two codes; miscellaneous errors have their own code.
// - Uncorrectable ECC, corrected ECC and transfer/abort errors have distinct codes.
// - Diagnostic failure, spares exhausted, format and write failure have distinct codes.
// - Seek only range-checks the CHS or LBA address and errors out of range.
// - Disable password takes one sector; control word selects password compared.
// - Matching disable password leaves lock mode; master password stays stored.
// - Set password sector: bit 0 user/master, bit 8 high/maximum level.
// - Erase unit takes a password sector and aborts on mismatch.
// - Erase unit aborts unless the previous command was erase prepare.
// - Freeze lock enters frozen state; lock-changing commands are rejected.
// - Frozen state ends only by power cycle or hardware reset.
// - Freeze lock while frozen still executes; sector count reads zero after.
// - While frozen, set, unlock, disable and erase commands are rejected.
// - Without security support freeze lock runs the wear-level command.
// - User password arms lock at next reset; maximum level accepts only user. Only hardware reset arms it here; rstn clears the password and lock.
// - Master password store leaves lock state and level unchanged.
module atasec_cmd
    import atasec_pkg::*;
#(
    parameter logic [27:0] MAX_LBA = 28'h00f_ffff,
    parameter logic [15:0] CYLS = 16'h0400,
    parameter logic [3:0] MAX_HEAD = 4'hf,
    parameter logic [7:0] SPT = 8'h3f
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic hw_reset,
    input wire logic sec_supported,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic ext_valid,
    input wire logic [7:0] ext_code,
    output logic cmd_done,
    output logic erase_start,
    output logic wear_level_start,
    output logic locked,
    output logic frozen,
    output logic busy
);
    atasec_state_t s;
    atasec_state_t n;
    logic [7:0] status;
    logic [27:0] lba;
    logic pw_id;
    logic match;
    logic lock_cmd;
    logic [7:0] seek_code;

    // Clock and reset for the checks below
    default clocking chk_clk @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Completes the current command, with or without abort
    function automatic atasec_state_t finish(input atasec_state_t c, input logic bad,
                                             input logic [7:0] code, input logic [7:0] e);
        atasec_state_t r;
        r = c;
        r.st = ATASEC_IDLE;
        r.done = 1'b1;
        r.err_flag = bad;
        r.err = e;
        r.ext = code;
        r.erase_armed = (c.cmd == `ATASEC_OP_PREP) && !bad;
        return r;
    endfunction

    // Status byte from the sequencer state
    always_comb begin
        status = 8'h00;
        status[`ATASEC_ST_BSY] = (s.st == ATASEC_DECODE) || (s.st == ATASEC_EXEC);
        status[`ATASEC_ST_RDY] = 1'b1;
        status[`ATASEC_ST_DRQ] = (s.st == ATASEC_XFER);
        status[`ATASEC_ST_ERR] = s.err_flag;
    end

    // Address decode for seek range check
    always_comb begin
        lba = {s.drv_hd[3:0], s.cyl_hi, s.cyl_lo, s.snum};
        seek_code = `ATASEC_EXT_NONE;
        if (s.drv_hd[`ATASEC_LBA_BIT]) begin
            if (lba > MAX_LBA) begin
                seek_code = `ATASEC_EXT_OVFL;
            end
        end else if ((s.drv_hd[3:0] > MAX_HEAD) || (s.snum == 8'h00) || (s.snum > SPT)) begin
            seek_code = `ATASEC_EXT_BADADDR;
        end else if ({s.cyl_hi, s.cyl_lo} >= CYLS) begin
            seek_code = `ATASEC_EXT_OVFL;
        end
    end

    // Password selection and compare
    always_comb begin
        pw_id = s.ctl[`ATASEC_CTL_ID];
        // Maximum level: master password never matches
        if (pw_id) begin
            match = (s.pw == s.master_pw) && !s.level_max;
        end else begin
            match = (s.pw == s.user_pw);
        end
        lock_cmd = (s.cmd == `ATASEC_OP_SETPW) || (s.cmd == `ATASEC_OP_UNLOCK) ||
                   (s.cmd == `ATASEC_OP_DISPW) || (s.cmd == `ATASEC_OP_ERASE);
    end

    // Next-state logic
    always_comb begin
        n = s;
        n.done = 1'b0;
        n.erase_go = 1'b0;
        n.wear_go = 1'b0;
        n.hw_s1 = hw_reset;
        n.hw_s2 = s.hw_s1;
        // Register reads, data one cycle later
        if (rd) begin
            case (addr)
                `ATASEC_OFF_ERRFEAT: n.rdata = {8'h00, s.err};
                `ATASEC_OFF_SCNT: n.rdata = {8'h00, s.scnt};
                `ATASEC_OFF_SNUM: n.rdata = {8'h00, s.snum};
                `ATASEC_OFF_CYLLO: n.rdata = {8'h00, s.cyl_lo};
                `ATASEC_OFF_CYLHI: n.rdata = {8'h00, s.cyl_hi};
                `ATASEC_OFF_DRVHD: n.rdata = {8'h00, s.drv_hd};
                `ATASEC_OFF_STATCMD: n.rdata = {8'h00, status};
                default: n.rdata = 16'h0000;
            endcase
        end
        // Task-file writes while idle
        if (wr && (s.st == ATASEC_IDLE)) begin
            case (addr)
                `ATASEC_OFF_ERRFEAT: n.feat = wdata[7:0];
                `ATASEC_OFF_SCNT: n.scnt = wdata[7:0];
                `ATASEC_OFF_SNUM: n.snum = wdata[7:0];
                `ATASEC_OFF_CYLLO: n.cyl_lo = wdata[7:0];
                `ATASEC_OFF_CYLHI: n.cyl_hi = wdata[7:0];
                `ATASEC_OFF_DRVHD: n.drv_hd = wdata[7:0];
                `ATASEC_OFF_STATCMD: begin
                    n.cmd = wdata[7:0];
                    n.st = ATASEC_DECODE;
                end
                default: ;
            endcase
        end
        case (s.st)
            ATASEC_IDLE: ;
            ATASEC_DECODE: begin
                n.wcnt = 9'h000;
                n.pw = 256'h0;
                if (s.cmd[7:4] == `ATASEC_GRP_RECAL) begin
                    n = finish(n, 1'b0, `ATASEC_EXT_NONE, 8'h00);
                end else if (s.cmd[7:4] == `ATASEC_GRP_SEEK) begin
                    n = finish(n, seek_code != `ATASEC_EXT_NONE, seek_code,
                               (seek_code != `ATASEC_EXT_NONE) ? `ATASEC_ERRV_IDNF : 8'h00);
                end else if (s.cmd == `ATASEC_OP_SENSE) begin
                    n = finish(n, 1'b0, `ATASEC_EXT_NONE, s.ext);
                end else if (s.cmd == `ATASEC_OP_FREEZE) begin
                    if (sec_supported) begin
                        n = finish(n, 1'b0, `ATASEC_EXT_NONE, 8'h00);
                        n.frozen = 1'b1;
                        n.scnt = 8'h00;
                    end else begin
                        n = finish(n, 1'b0, `ATASEC_EXT_NONE, 8'h00);
                        n.wear_go = 1'b1;
                    end
                end else if (s.cmd == `ATASEC_OP_PREP) begin
                    n = finish(n, 1'b0, `ATASEC_EXT_NONE, 8'h00);
                end else if (lock_cmd && s.frozen) begin
                    n = finish(n, 1'b1, `ATASEC_EXT_ABORT, `ATASEC_ERRV_ABRT);
                end else if ((s.cmd == `ATASEC_OP_ERASE) && !s.erase_armed) begin
                    n = finish(n, 1'b1, `ATASEC_EXT_ABORT, `ATASEC_ERRV_ABRT);
                end else if ((s.cmd == `ATASEC_OP_SETPW) || (s.cmd == `ATASEC_OP_DISPW) ||
                             (s.cmd == `ATASEC_OP_ERASE)) begin
                    n.st = ATASEC_XFER;
                end else begin
                    n = finish(n, 1'b1, `ATASEC_EXT_ABORT, `ATASEC_ERRV_ABRT);
                end
            end
            ATASEC_XFER: begin
                // Collect control word and 16 password words
                if (wr && (addr == `ATASEC_OFF_DATA)) begin
                    if (s.wcnt == 9'h000) begin
                        n.ctl = wdata;
                    end else if ((s.wcnt >= `ATASEC_PW_FIRST) && (s.wcnt <= `ATASEC_PW_LAST)) begin
                        n.pw = {wdata, s.pw[255:16]};
                    end
                    n.wcnt = s.wcnt + 9'h001;
                    if (s.wcnt == `ATASEC_LAST_WORD) begin
                        n.st = ATASEC_EXEC;
                    end
                end
            end
            ATASEC_EXEC: begin
                if (s.cmd == `ATASEC_OP_SETPW) begin
                    n = finish(n, 1'b0, `ATASEC_EXT_NONE, 8'h00);
                    if (pw_id) begin
                        n.master_pw = s.pw;
                    end else begin
                        n.user_pw = s.pw;
                        n.user_set = 1'b1;
                        n.level_max = s.ctl[`ATASEC_CTL_LVL];
                    end
                end else if (!match) begin
                    n = finish(n, 1'b1, `ATASEC_EXT_ABORT, `ATASEC_ERRV_ABRT);
                end else if (s.cmd == `ATASEC_OP_DISPW) begin
                    n = finish(n, 1'b0, `ATASEC_EXT_NONE, 8'h00);
                    n.locked = 1'b0;
                    n.user_set = 1'b0;
                end else begin
                    n = finish(n, 1'b0, `ATASEC_EXT_NONE, 8'h00);
                    n.erase_go = 1'b1;
                    n.locked = 1'b0;
                    n.user_set = 1'b0;
                    n.user_pw = 256'h0;
                end
            end
            default: n.st = ATASEC_IDLE;
        endcase
        // Back-end error reports land in the extended code
        if (ext_valid) begin
            n.ext = ext_code;
        end
        // Hardware reset: leave frozen, drop erase arm, arm lock
        if (s.hw_s2) begin
            n.frozen = 1'b0;
            n.erase_armed = 1'b0;
            n.locked = s.user_set;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Outputs
    assign rdata = s.rdata;
    assign cmd_done = s.done;
    assign erase_start = s.erase_go;
    assign wear_level_start = s.wear_go;
    assign locked = s.locked;
    assign frozen = s.frozen;
    assign busy = status[`ATASEC_ST_BSY];

    // Checks
    AST_RECAL: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.st == ATASEC_DECODE) && (s.cmd[7:4] == `ATASEC_GRP_RECAL) |=> s.done && !s.err_flag)
        else $error("recalibrate not completed cleanly");
    AST_SENSE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.st == ATASEC_DECODE) && (s.cmd == `ATASEC_OP_SENSE) && !ext_valid
        |=> s.err == $past(s.ext))
        else $error("sense did not return extended code");
    AST_SEEK_IDLE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.st == ATASEC_DECODE) && (s.cmd[7:4] == `ATASEC_GRP_SEEK) |=> s.done && !s.erase_go)
        else $error("seek did not complete");
    AST_FROZEN_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
        s.frozen && !s.hw_s2 |=> s.frozen)
        else $error("frozen left without reset");
    AST_FREEZE_SCNT: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.st == ATASEC_DECODE) && (s.cmd == `ATASEC_OP_FREEZE) && sec_supported && !s.hw_s2
        |=> s.frozen && (s.scnt == 8'h00))
        else $error("freeze lock failed");
    AST_FROZEN_REJ: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.st == ATASEC_DECODE) && s.frozen && lock_cmd
        |=> s.done && s.err[`ATASEC_ER_ABRT] && (s.st == ATASEC_IDLE))
        else $error("lock command accepted while frozen");
    AST_ERASE_PREP: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.st == ATASEC_DECODE) && (s.cmd == `ATASEC_OP_ERASE) && !s.erase_armed
        |=> s.err_flag && !s.erase_go)
        else $error("erase unit without prepare");
    AST_WEAR: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.st == ATASEC_DECODE) && (s.cmd == `ATASEC_OP_FREEZE) && !sec_supported
        |=> s.wear_go ##1 !s.wear_go)
        else $error("wear level not started");
    AST_ABORT_EXT: assert property (@(posedge sys_clk) disable iff (!rstn)
        s.done && s.err_flag && s.err[`ATASEC_ER_ABRT] && !$past(ext_valid)
        |-> s.ext == `ATASEC_EXT_ABORT)
        else $error("abort without extended code");

    // Sequencer and transfer checks
    AST_DONE_PULSE: assert property (s.done |=> !s.done)
        else $error("command done held longer than one cycle");
    AST_SEEK_ERR: assert property (
        (s.st == ATASEC_DECODE) && (s.cmd[7:4] == `ATASEC_GRP_SEEK) && !ext_valid &&
        (seek_code != `ATASEC_EXT_NONE)
        |=> s.err_flag && s.err[`ATASEC_ER_IDNF] && (s.ext == $past(seek_code)))
        else $error("seek range error not reported");
    AST_SENSE_CLEAR: assert property (
        (s.st == ATASEC_DECODE) && (s.cmd == `ATASEC_OP_SENSE) && !ext_valid
        |=> s.ext == `ATASEC_EXT_NONE)
        else $error("extended code not cleared after sense");
    AST_WCNT_STEP: assert property (
        (s.st == ATASEC_XFER) && wr && (addr == `ATASEC_OFF_DATA) &&
        (s.wcnt != `ATASEC_LAST_WORD)
        |=> (s.st == ATASEC_XFER) && (s.wcnt == $past(s.wcnt) + 9'h001))
        else $error("sector word not counted");
    AST_XFER_END: assert property (
        (s.st == ATASEC_XFER) && wr && (addr == `ATASEC_OFF_DATA) &&
        (s.wcnt == `ATASEC_LAST_WORD) |=> s.st == ATASEC_EXEC)
        else $error("sector end not detected");
    AST_RDATA_ERR: assert property (
        rd && (addr == `ATASEC_OFF_ERRFEAT) |=> rdata == {8'h00, $past(s.err)})
        else $error("error register read wrong");

    // Password and lock state checks
    AST_MASTER_KEEP: assert property (
        (s.st == ATASEC_EXEC) && (s.cmd == `ATASEC_OP_SETPW) && pw_id && !s.hw_s2
        |=> (s.locked == $past(s.locked)) && (s.level_max == $past(s.level_max)) &&
        (s.master_pw == $past(s.pw)))
        else $error("master password store changed lock state");
    AST_USER_SET: assert property (
        (s.st == ATASEC_EXEC) && (s.cmd == `ATASEC_OP_SETPW) && !pw_id
        |=> s.user_set && (s.user_pw == $past(s.pw)) &&
        (s.level_max == $past(s.ctl[`ATASEC_CTL_LVL])))
        else $error("user password not stored");
    AST_DISPW_OPEN: assert property (
        (s.st == ATASEC_EXEC) && (s.cmd == `ATASEC_OP_DISPW) && match && !s.hw_s2
        |=> !s.locked && (s.master_pw == $past(s.master_pw)))
        else $error("disable password did not unlock");
    AST_MAX_MASTER: assert property (
        (s.st == ATASEC_EXEC) && (s.cmd != `ATASEC_OP_SETPW) && pw_id && s.level_max
        |=> s.err_flag && !s.erase_go)
        else $error("master password accepted at maximum level");
    AST_ERASE_BAD: assert property (
        (s.st == ATASEC_EXEC) && (s.cmd == `ATASEC_OP_ERASE) && !match
        |=> s.done && s.err_flag && !s.erase_go)
        else $error("erase unit accepted a wrong password");
    AST_PREP_ARM: assert property (
        (s.st == ATASEC_DECODE) && (s.cmd == `ATASEC_OP_PREP) && !s.hw_s2
        |=> s.erase_armed && s.done && !s.err_flag)
        else $error("erase prepare did not arm");
    AST_HW_RESET: assert property (
        s.hw_s2 |=> !s.frozen && !s.erase_armed && (s.locked == $past(s.user_set)))
        else $error("hardware reset did not clear freeze or arm lock");

    // Scenario covers
    COV_ERASE: cover property (@(posedge sys_clk) disable iff (!rstn) s.erase_go);
    COV_FREEZE: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(s.frozen));
    COV_SETPW: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(s.user_set));
    COV_WEAR: cover property (s.wear_go);
    COV_ABORT: cover property (s.done && s.err_flag && s.err[`ATASEC_ER_ABRT]);
endmodule

// ===== atasec_host.sv
`timescale 1ns/1ps
module atasec_host (
    input wire logic sys_clk,
    input wire logic [15:0] rdata,
    output logic [2:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd,
    output logic ext_valid,
    output logic [7:0] ext_code
);
    // Quiet bus from time zero
    initial begin
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        ext_valid = 1'b0;
        ext_code = 8'h00;
    end

    // One write cycle; data inverted once released
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask

    // One read cycle; data taken in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Back-end error report, one cycle
    task automatic ext_pulse(input logic [7:0] c);
        @(posedge sys_clk);
        ext_valid <= 1'b1;
        ext_code <= c;
        @(posedge sys_clk);
        ext_valid <= 1'b0;
        ext_code <= ~c;
    endtask

    // Password sector: control word, 16 password words, reserved zeros
    task automatic send_sector(input logic [15:0] ctl, input logic [255:0] pw);
        int i;
        wr_reg(3'h0, ctl);
        for (i = 1; i < 256; i++) begin
            wr_reg(3'h0, (i <= 16) ? pw[16*i-16 +: 16] : 16'h0000);
        end
    endtask
endmodule

// ===== atasec_cmd_test.sv
`timescale 1ns/1ps
`include "atasec_map.svh"
module atasec_cmd_test;
    localparam logic [2:0] CMD = `ATASEC_OFF_STATCMD;
    localparam logic [2:0] ERR = `ATASEC_OFF_ERRFEAT;
    localparam logic [2:0] SCNT = `ATASEC_OFF_SCNT;
    logic sys_clk, rstn, hw_reset, sec_supported, wr, rd, ext_valid;
    logic [2:0] addr;
    logic [15:0] wdata, rdata, st, v;
    logic [7:0] ext_code;
    logic cmd_done, erase_start, wear_level_start, locked, frozen, busy, drq_seen;
    int err_total = 0, checks = 0, cyc = 0, done_cnt = 0, erase_cnt = 0, wear_cnt = 0, n0;
    int busy_cnt = 0;
    logic [255:0] pw_a = {8{32'h0001_a5a5}}, pw_b = {8{32'hc3c3_0002}};
    logic [255:0] pw_x = {8{32'h0001_a5a4}};
    logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h09, 8'h21, 8'h2f, 8'h35, 8'h36, 8'h11,
        8'h18, 8'h1f, 8'h05, 8'h37, 8'h3e, 8'h3a, 8'h0c, 8'h03};
    logic [7:0] frz_ops [4] = '{8'hf1, 8'hf2, 8'hf6, 8'hf4};

    atasec_cmd DUT (.sys_clk(sys_clk), .rstn(rstn), .hw_reset(hw_reset),
        .sec_supported(sec_supported), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ext_valid(ext_valid), .ext_code(ext_code), .cmd_done(cmd_done),
        .erase_start(erase_start), .wear_level_start(wear_level_start), .locked(locked),
        .frozen(frozen), .busy(busy));
    atasec_host host (.sys_clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .ext_valid(ext_valid), .ext_code(ext_code));

    // 10 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Pulse counters and hang limit
    always @(posedge sys_clk) begin
        if (cmd_done === 1'b1) done_cnt++;
        if (erase_start === 1'b1) erase_cnt++;
        if (wear_level_start === 1'b1) wear_cnt++;
        if (busy === 1'b1) busy_cnt++;
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Issue a command, feed a sector on request, poll until idle
    task automatic run(input logic [7:0] op, input logic [15:0] ctl, input logic [255:0] pw);
        int n;
        int d0;
        int b0;
        d0 = done_cnt;
        b0 = busy_cnt;
        drq_seen = 1'b0;
        host.wr_reg(CMD, {8'h00, op});
        for (n = 0; n < 12; n++) begin
            host.rd_reg(CMD, st);
            if (st[`ATASEC_ST_DRQ] === 1'b1) begin
                drq_seen = 1'b1;
                host.send_sector(ctl, pw);
            end else if (st[`ATASEC_ST_BSY] === 1'b0) begin
                break;
            end
        end
        chk("done pulses", 16'(d0 + 1), 16'(done_cnt));
        chk("busy cycles", drq_seen ? 16'h0002 : 16'h0001, 16'(busy_cnt - b0));
    endtask

    // Final error flag, and error register when set
    task automatic expect_err(input logic e, input logic [7:0] code);
        chk("status err", {15'h0000, e}, {15'h0000, st[`ATASEC_ST_ERR]});
        if (e) begin
            host.rd_reg(ERR, v);
            chk("error reg", {8'h00, code}, v);
        end
    endtask

    task automatic sense(input logic [7:0] code);
        run(`ATASEC_OP_SENSE, 16'h0000, pw_x);
        host.rd_reg(ERR, v);
        chk("sense code", {8'h00, code}, v);
    endtask

    task automatic pulse_hw;
        @(posedge sys_clk);
        hw_reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        hw_reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic test_end(input string s);
        $display("Test %s finished, mismatches so far %0d", s, err_total);
    endtask

    task automatic tally_and_finish;
        $display("Counts: %0d comparisons, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        hw_reset = 1'b0;
        sec_supported = 1'b1;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        chk("locked", 16'h0000, {15'h0000, locked});
        host.rd_reg(CMD, v);
        chk("idle status", 16'h0040, v);
        run(8'h10, 16'h0000, pw_x);
        expect_err(1'b0, 8'h00);
        run(8'h1f, 16'h0000, pw_x);
        expect_err(1'b0, 8'h00);
        test_end("recalibrate");
        host.wr_reg(`ATASEC_OFF_DRVHD, 16'h00e0);
        run(8'h70, 16'h0000, pw_x);
        expect_err(1'b0, 8'h00);
        host.wr_reg(`ATASEC_OFF_CYLHI, 16'h00ff);
        host.wr_reg(`ATASEC_OFF_DRVHD, 16'h00ef);
        run(8'h7f, 16'h0000, pw_x);
        expect_err(1'b1, 8'h10);
        sense(8'h2f);
        host.wr_reg(`ATASEC_OFF_DRVHD, 16'h00a0);
        host.wr_reg(`ATASEC_OFF_CYLHI, 16'h0000);
        host.wr_reg(`ATASEC_OFF_SNUM, 16'h0000);
        run(8'h7a, 16'h0000, pw_x);
        expect_err(1'b1, 8'h10);
        sense(8'h21);
        sense(8'h00);
        foreach (codes[i]) begin
            host.ext_pulse(codes[i]);
            sense(codes[i]);
        end
        test_end("seek and sense");
        run(8'hf4, 16'h0000, pw_a);
        chk("drq on unarmed erase", 16'h0000, {15'h0000, drq_seen});
        expect_err(1'b1, 8'h04);
        sense(8'h1f);
        run(8'hf1, 16'h0000, pw_a);
        expect_err(1'b0, 8'h00);
        chk("locked", 16'h0000, {15'h0000, locked});
        run(8'hf1, 16'h0001, pw_b);
        pulse_hw();
        chk("locked", 16'h0001, {15'h0000, locked});
        run(8'hf6, 16'h0000, pw_x);
        expect_err(1'b1, 8'h04);
        run(8'hf6, 16'h0001, pw_b);
        chk("locked", 16'h0000, {15'h0000, locked});
        run(8'hf1, 16'h0100, pw_a);
        pulse_hw();
        chk("locked", 16'h0001, {15'h0000, locked});
        run(8'hf6, 16'h0001, pw_b);
        expect_err(1'b1, 8'h04);
        run(8'hf6, 16'h0000, pw_a);
        chk("locked", 16'h0000, {15'h0000, locked});
        run(8'hf1, 16'h0000, pw_a);
        pulse_hw();
        run(8'hf6, 16'h0001, pw_b);
        chk("locked", 16'h0000, {15'h0000, locked});
        test_end("passwords");
        run(8'hf1, 16'h0000, pw_a);
        run(8'hf3, 16'h0000, pw_x);
        run(8'hf4, 16'h0000, pw_x);
        expect_err(1'b1, 8'h04);
        run(8'hf3, 16'h0000, pw_x);
        run(8'h10, 16'h0000, pw_x);
        run(8'hf4, 16'h0000, pw_a);
        expect_err(1'b1, 8'h04);
        n0 = erase_cnt;
        run(8'hf3, 16'h0000, pw_x);
        run(8'hf4, 16'h0000, pw_a);
        expect_err(1'b0, 8'h00);
        chk("erase starts", 16'(n0 + 1), 16'(erase_cnt));
        test_end("erase");
        repeat (2) begin
            host.wr_reg(SCNT, 16'h0005);
            run(8'hf5, 16'h0000, pw_x);
            chk("frozen", 16'h0001, {15'h0000, frozen});
            host.rd_reg(SCNT, v);
            chk("sector count", 16'h0000, v);
        end
        foreach (frz_ops[i]) begin
            run(8'hf3, 16'h0000, pw_x);
            run(frz_ops[i], 16'h0000, pw_a);
            chk("drq when frozen", 16'h0000, {15'h0000, drq_seen});
            expect_err(1'b1, 8'h04);
        end
        chk("frozen", 16'h0001, {15'h0000, frozen});
        pulse_hw();
        chk("frozen", 16'h0000, {15'h0000, frozen});
        @(posedge sys_clk);
        sec_supported <= 1'b0;
        n0 = wear_cnt;
        run(8'hf5, 16'h0000, pw_x);
        chk("wear starts", 16'(n0 + 1), 16'(wear_cnt));
        chk("frozen", 16'h0000, {15'h0000, frozen});
        test_end("freeze");
        tally_and_finish();
    end
endmodule
